// ---- rtl/rpm_pkg.sv ----
// rpm_pkg.sv - constants, offsets and types for the remappable pin output mux
package rpm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned RPM_NPINS = 4;
  localparam int unsigned RPM_SELW  = 6;
  localparam int unsigned RPM_NFUNC = 63;
  localparam int unsigned RPM_AW    = 8;
  localparam int unsigned RPM_DW    = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [RPM_AW-1:0] RPM_OFF_SEL2  = 8'h00;
  localparam logic [RPM_AW-1:0] RPM_OFF_SEL3  = 8'h04;
  localparam logic [RPM_AW-1:0] RPM_OFF_ANSEL = 8'h08;
  localparam logic [RPM_AW-1:0] RPM_OFF_DIR   = 8'h0C;
  localparam logic [RPM_AW-1:0] RPM_OFF_LAT   = 8'h10;
  localparam logic [RPM_AW-1:0] RPM_OFF_PINS  = 8'h14;

  // decoded register index
  localparam logic [2:0] RPM_IDX_SEL2  = 3'h0;
  localparam logic [2:0] RPM_IDX_SEL3  = 3'h1;
  localparam logic [2:0] RPM_IDX_ANSEL = 3'h2;
  localparam logic [2:0] RPM_IDX_DIR   = 3'h3;
  localparam logic [2:0] RPM_IDX_LAT   = 3'h4;
  localparam logic [2:0] RPM_IDX_PINS  = 3'h5;
  localparam logic [2:0] RPM_IDX_NONE  = 3'h7;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned             RPM_LO_LSB    = 0;
  localparam int unsigned             RPM_HI_LSB    = 8;
  localparam logic [15:0]             RPM_SEL_MASK  = 16'h3F3F;
  localparam logic [15:0]             RPM_SEL_RST   = 16'h0000;
  localparam logic [RPM_NPINS-1:0]    RPM_ANSEL_RST = 4'hF;
  localparam logic [RPM_NPINS-1:0]    RPM_DIR_RST   = 4'hF;
  localparam logic [RPM_NPINS-1:0]    RPM_LAT_RST   = 4'h0;
  localparam logic [RPM_SELW-1:0]     RPM_SEL_NONE  = 6'h00;
  localparam logic [1:0]              RPM_RESP_OKAY = 2'h0;
  localparam logic [1:0]              RPM_RESP_SLV  = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic oe;
    logic o;
  } rpm_drive_s;

  typedef enum logic {
    RPM_RD_IDLE,
    RPM_RD_DATA
  } rpm_rd_e;

endpackage

// ---- rtl/rpm_sync.sv ----
// rpm_sync.sv - two flip-flop synchroniser for pad inputs
`timescale 1ns/10ps
module rpm_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // rpm_sync

// ---- rtl/rpm_pin_cell.sv ----
// rpm_pin_cell.sv - output source selection for one remappable pin
`timescale 1ns/10ps
module rpm_pin_cell
  import rpm_pkg::*;
#(
  parameter int unsigned NFUNC = RPM_NFUNC
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // sources
  input  wire logic                ded_en,
  input  wire logic                ded_o,
  input  wire logic [RPM_SELW-1:0] sel,
  input  wire logic [NFUNC-1:0]    periph_out,
  input  wire logic                dir_in,
  input  wire logic                lat,
  // pad drive
  output rpm_drive_s               drive
);

  // ----------------------------------------------------------------
  // selector decode
  // ----------------------------------------------------------------
  function automatic logic sel_routes(logic [RPM_SELW-1:0] s);
    sel_routes = (s != RPM_SEL_NONE) && (32'(s) <= NFUNC);
  endfunction

  logic fn_val;
  logic remap_on;

  assign remap_on = sel_routes(sel);
  assign fn_val   = remap_on ? periph_out[sel - 6'h01] : 1'b0;

  // ----------------------------------------------------------------
  // one output per pin, by priority
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
    end else if (ded_en) begin
      drive <= '{oe: 1'b1, o: ded_o};
    end else if (remap_on) begin
      drive <= '{oe: 1'b1, o: fn_val};
    end else begin
      drive <= '{oe: !dir_in, o: lat};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ded_priority: assert property (@(posedge aclk) disable iff (!aresetn)
    ded_en |=> drive.oe && drive.o == $past(ded_o))
    else $error("dedicated output lost priority");

  chk_remap_override: assert property (@(posedge aclk) disable iff (!aresetn)
    !ded_en && sel_routes(sel) |=> drive.oe && drive.o == $past(fn_val))
    else $error("remapped output did not override direction");

  chk_sel_zero_gpio: assert property (@(posedge aclk) disable iff (!aresetn)
    !ded_en && sel == RPM_SEL_NONE |=> drive.oe == !$past(dir_in) && drive.o == $past(lat))
    else $error("zero selector routed a peripheral");

endmodule // rpm_pin_cell

// ---- rtl/rpm_top.sv ----
// rpm_top.sv - remappable pin output mux with axi4-lite register slave
`timescale 1ns/10ps

// Functional notes
// - only one output source drives any pin at a time
// - one remappable function may be routed to several pins at once
// - dedicated output on a pin wins over a remapped output
// - remappable inputs still sample a pin while a dedicated function is on
// - analog selection disables digital inputs; one digital output may still drive
// - any number of remappable inputs may share pins, also pins with an output
// - direction bit gates only the gpio buffer; other outputs override it
// - remappable inputs do not override direction; software sets direction to input
// - after reset analog pins come up analog with digital inputs off
// - only analog select gates the digital input buffer; software clears it first
// - select register 2: pin 39 in bits 13-8, pin 38 in 5-0, rest zero
// - select register 3: pin 41 in 13-8, pin 40 in 5-0, reset zero
module rpm_top
  import rpm_pkg::*;
#(
  parameter int unsigned FUNC_COUNT = RPM_NFUNC
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [RPM_AW-1:0]     s_awaddr,
  input  wire logic [2:0]            s_awprot,
  // axi4-lite write data
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  input  wire logic [RPM_DW-1:0]     s_wdata,
  input  wire logic [3:0]            s_wstrb,
  // axi4-lite write response
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  output logic [1:0]                 s_bresp,
  // axi4-lite read address
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  input  wire logic [RPM_AW-1:0]     s_araddr,
  input  wire logic [2:0]            s_arprot,
  // axi4-lite read data
  output logic                       s_rvalid,
  input  wire logic                  s_rready,
  output logic [RPM_DW-1:0]          s_rdata,
  output logic [1:0]                 s_rresp,
  // peripheral side
  input  wire logic [FUNC_COUNT-1:0] periph_out,
  input  wire logic [RPM_NPINS-1:0]  ded_out_en,
  input  wire logic [RPM_NPINS-1:0]  ded_out,
  output logic      [RPM_NPINS-1:0]  rp_pin_in,
  // pads, index 0..3 are remappable pins 38..41
  input  wire logic [RPM_NPINS-1:0]  pad_in,
  output logic      [RPM_NPINS-1:0]  pad_o,
  output logic      [RPM_NPINS-1:0]  pad_oe,
  output logic      [RPM_NPINS-1:0]  pad_ie
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(logic [RPM_AW-1:0] a);
    case ({a[RPM_AW-1:2], 2'h0})
      RPM_OFF_SEL2:  reg_index = RPM_IDX_SEL2;
      RPM_OFF_SEL3:  reg_index = RPM_IDX_SEL3;
      RPM_OFF_ANSEL: reg_index = RPM_IDX_ANSEL;
      RPM_OFF_DIR:   reg_index = RPM_IDX_DIR;
      RPM_OFF_LAT:   reg_index = RPM_IDX_LAT;
      RPM_OFF_PINS:  reg_index = RPM_IDX_PINS;
      default:       reg_index = RPM_IDX_NONE;
    endcase
  endfunction

  function automatic logic [15:0] merge16(logic [15:0] old, logic [RPM_DW-1:0] d, logic [3:0] s);
    logic [15:0] m;
    m[7:0]   = s[0] ? d[7:0] : old[7:0];
    m[15:8]  = s[1] ? d[15:8] : old[15:8];
    merge16  = m & RPM_SEL_MASK;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]           sel2_q;
  logic [15:0]           sel3_q;
  logic [RPM_NPINS-1:0]  ansel_q;
  logic [RPM_NPINS-1:0]  dir_q;
  logic [RPM_NPINS-1:0]  lat_q;
  logic [RPM_NPINS-1:0]  pin_sync;
  logic [RPM_SELW-1:0]   pin_sel [RPM_NPINS];

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic                  aw_held_q;
  logic                  w_held_q;
  logic [RPM_AW-1:0]     aw_addr_q;
  logic [RPM_DW-1:0]     w_data_q;
  logic [3:0]            w_strb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  aw_hs;
  logic                  w_hs;
  logic                  wr_fire;
  logic [RPM_AW-1:0]     wr_addr;
  logic [RPM_DW-1:0]     wr_data;
  logic [3:0]            wr_strb;
  logic [2:0]            wr_idx;

  assign s_awready = !aw_held_q && !bvalid_q;
  assign s_wready  = !w_held_q && !bvalid_q;
  assign aw_hs     = s_awvalid && s_awready;
  assign w_hs      = s_wvalid && s_wready;
  assign wr_fire   = (aw_held_q || aw_hs) && (w_held_q || w_hs);
  assign wr_addr   = aw_held_q ? aw_addr_q : s_awaddr;
  assign wr_data   = w_held_q ? w_data_q : s_wdata;
  assign wr_strb   = w_held_q ? w_strb_q : s_wstrb;
  assign wr_idx    = reg_index(wr_addr);
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end else if (aw_hs) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end else if (w_hs) begin
      w_held_q <= 1'b1;
      w_data_q <= s_wdata;
      w_strb_q <= s_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RPM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_idx == RPM_IDX_NONE || wr_idx == RPM_IDX_PINS) ? RPM_RESP_SLV : RPM_RESP_OKAY;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // register file; analog select resets to all-analog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel2_q  <= RPM_SEL_RST;
      sel3_q  <= RPM_SEL_RST;
      ansel_q <= RPM_ANSEL_RST;
      dir_q   <= RPM_DIR_RST;
      lat_q   <= RPM_LAT_RST;
    end else if (wr_fire) begin
      case (wr_idx)
        RPM_IDX_SEL2:  sel2_q <= merge16(sel2_q, wr_data, wr_strb);
        RPM_IDX_SEL3:  sel3_q <= merge16(sel3_q, wr_data, wr_strb);
        RPM_IDX_ANSEL: if (wr_strb[0]) ansel_q <= wr_data[RPM_NPINS-1:0];
        RPM_IDX_DIR:   if (wr_strb[0]) dir_q <= wr_data[RPM_NPINS-1:0];
        RPM_IDX_LAT:   if (wr_strb[0]) lat_q <= wr_data[RPM_NPINS-1:0];
        default:       ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  rpm_rd_e               rd_st_q;
  logic [RPM_DW-1:0]     rdata_q;
  logic [1:0]            rresp_q;
  logic [2:0]            rd_idx_q;
  logic [2:0]            ar_idx;
  logic [RPM_DW-1:0]     rd_val;

  assign ar_idx    = reg_index(s_araddr);
  assign s_arready = (rd_st_q == RPM_RD_IDLE);
  assign s_rvalid  = (rd_st_q == RPM_RD_DATA);
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  always_comb begin
    rd_val = '0;
    case (ar_idx)
      RPM_IDX_SEL2:  rd_val[15:0] = sel2_q & RPM_SEL_MASK;
      RPM_IDX_SEL3:  rd_val[15:0] = sel3_q & RPM_SEL_MASK;
      RPM_IDX_ANSEL: rd_val[RPM_NPINS-1:0] = ansel_q;
      RPM_IDX_DIR:   rd_val[RPM_NPINS-1:0] = dir_q;
      RPM_IDX_LAT:   rd_val[RPM_NPINS-1:0] = lat_q;
      RPM_IDX_PINS:  rd_val[RPM_NPINS-1:0] = rp_pin_in;
      default:       rd_val = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_q  <= RPM_RD_IDLE;
      rdata_q  <= '0;
      rresp_q  <= RPM_RESP_OKAY;
      rd_idx_q <= RPM_IDX_NONE;
    end else begin
      case (rd_st_q)
        RPM_RD_IDLE: if (s_arvalid) begin
          rd_st_q  <= RPM_RD_DATA;
          rdata_q  <= rd_val;
          rd_idx_q <= ar_idx;
          rresp_q  <= (ar_idx == RPM_IDX_NONE) ? RPM_RESP_SLV : RPM_RESP_OKAY;
        end
        RPM_RD_DATA: if (s_rready) begin
          rd_st_q <= RPM_RD_IDLE;
        end
        default: rd_st_q <= RPM_RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin output path
  // ----------------------------------------------------------------
  assign pin_sel[0] = sel2_q[RPM_LO_LSB +: RPM_SELW];
  assign pin_sel[1] = sel2_q[RPM_HI_LSB +: RPM_SELW];
  assign pin_sel[2] = sel3_q[RPM_LO_LSB +: RPM_SELW];
  assign pin_sel[3] = sel3_q[RPM_HI_LSB +: RPM_SELW];

  // analog selection does not block the output drivers
  for (genvar i = 0; i < RPM_NPINS; i++) begin : g_pin
    rpm_drive_s drv;
    rpm_pin_cell #(
      .NFUNC      (FUNC_COUNT)
    ) u_cell (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .ded_en     (ded_out_en[i]),
      .ded_o      (ded_out[i]),
      .sel        (pin_sel[i]),
      .periph_out (periph_out),
      .dir_in     (dir_q[i]),
      .lat        (lat_q[i]),
      .drive      (drv)
    );
    assign pad_o[i]  = drv.o;
    assign pad_oe[i] = drv.oe;
  end

  // ----------------------------------------------------------------
  // pin input path
  // ----------------------------------------------------------------
  rpm_sync #(
    .W        (RPM_NPINS)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pad_in),
    .sync_out (pin_sync)
  );

  // only analog select gates the input buffer; direction and outputs do not
  assign pad_ie = ~ansel_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rp_pin_in <= '0;
    end else begin
      rp_pin_in <= pin_sync & ~ansel_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_analog_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> pad_ie == '0 && ansel_q == RPM_ANSEL_RST)
    else $error("pins not analog after reset");

  chk_analog_input_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (rp_pin_in & $past(ansel_q)) == '0)
    else $error("digital input passed on an analog pin");

  chk_input_with_output: assert property (@(posedge aclk) disable iff (!aresetn)
    pad_oe[0] && !ansel_q[0] |=> rp_pin_in[0] == $past(pin_sync[0]))
    else $error("input blocked on a driven pin");

  chk_input_dedicated: assert property (@(posedge aclk) disable iff (!aresetn)
    ded_out_en[1] && !ansel_q[1] |=> rp_pin_in[1] == $past(pin_sync[1]))
    else $error("input blocked by dedicated function");

  chk_dir_no_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !dir_q[2] && !ansel_q[2] ##1 !$past(ansel_q[2]) |-> rp_pin_in[2] == $past(pin_sync[2]))
    else $error("direction gated the input buffer");

  chk_sel_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rvalid && (rd_idx_q == RPM_IDX_SEL2 || rd_idx_q == RPM_IDX_SEL3) |-> s_rdata[15:14] == 2'h0
      && s_rdata[7:6] == 2'h0 && s_rdata[31:16] == 16'h0000)
    else $error("reserved selector bits read nonzero");

  chk_sel3_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> sel3_q == RPM_SEL_RST && sel2_q == RPM_SEL_RST)
    else $error("selector registers not zero after reset");

  chk_shared_func: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_sel[0] == pin_sel[2] && pin_sel[0] != RPM_SEL_NONE && !ded_out_en[0] && !ded_out_en[2]
      |=> pad_oe[0] && pad_oe[2] && pad_o[0] == pad_o[2])
    else $error("shared function differs between pins");

  chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_bvalid ##0 !s_awready && !s_wready)
    else $error("write response missing");

  cov_remap_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_idx == RPM_IDX_SEL2);

  cov_ded_override: cover property (@(posedge aclk) disable iff (!aresetn)
    ded_out_en[0] && pin_sel[0] != RPM_SEL_NONE);

  cov_shared_pins: cover property (@(posedge aclk) disable iff (!aresetn)
    pin_sel[1] == pin_sel[2] && pin_sel[1] != RPM_SEL_NONE ##1 pad_oe[1] && pad_oe[2]);

  cov_digital_in: cover property (@(posedge aclk) disable iff (!aresetn)
    !ansel_q[0] ##2 rp_pin_in[0]);

endmodule // rpm_top

// ---- bench/rpm_pad_model.sv ----
// rpm_pad_model.sv - board-side model of the four remappable pads
`timescale 1ns/10ps
module rpm_pad_model
  import rpm_pkg::*;
(
  // clock
  input  wire logic                 aclk,
  // device pad drive
  input  wire logic [RPM_NPINS-1:0] pad_o,
  input  wire logic [RPM_NPINS-1:0] pad_oe,
  // external source on the board
  input  wire logic [RPM_NPINS-1:0] ext_en,
  input  wire logic [RPM_NPINS-1:0] ext_val,
  // level seen by the device
  output logic      [RPM_NPINS-1:0] pad_in
);
  logic [RPM_NPINS-1:0] last_q = 4'h0;
  logic [RPM_NPINS-1:0] held;

  // no pull on these pads: a released pad shows the inverse of the last level driven onto it
  assign held = pad_oe | ext_en;

  always_ff @(posedge aclk) begin
    last_q <= (held & pad_in) | (~held & last_q);
  end

  // device drive first, then the board source, else the floating level
  always_comb begin
    pad_in = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_val) | (~held & ~last_q);
  end
endmodule // rpm_pad_model

// ---- bench/testbench.sv ----
// testbench.sv - register and pin checks for the remappable pin output mux
`timescale 1ns/10ps
module testbench
  import rpm_pkg::*;
;
  logic                 aclk, aresetn;
  logic                 s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic                 s_arvalid, s_arready, s_rvalid, s_rready;
  logic [RPM_AW-1:0]    s_awaddr, s_araddr;
  logic [RPM_DW-1:0]    s_wdata, s_rdata;
  logic [3:0]           s_wstrb;
  logic [1:0]           s_bresp, s_rresp;
  logic [RPM_NFUNC-1:0] periph_out;
  logic [RPM_NPINS-1:0] ded_out_en, ded_out, rp_pin_in, pad_in, pad_o, pad_oe, pad_ie, ext_en, ext_val;
  int                   fails, comparisons;

  always #20 aclk = ~aclk;

  rpm_top uut (
    .aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_awprot(3'h0), .s_wvalid, .s_wready,
    .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr,
    .s_arprot(3'h0), .s_rvalid, .s_rready, .s_rdata, .s_rresp, .periph_out, .ded_out_en,
    .ded_out, .rp_pin_in, .pad_in, .pad_o, .pad_oe, .pad_ie
  );

  rpm_pad_model far (.aclk, .pad_o, .pad_oe, .ext_en, .ext_val, .pad_in);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_awvalid <= 1'b1;
    s_awaddr  <= a;
    s_wvalid  <= 1'b1;
    s_wdata   <= d;
    s_bready  <= 1'b1;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid && s_bready) begin
        done = 1'b1;
        s_bready <= 1'b0;
        chk({30'h0, s_bresp}, {30'h0, er});
      end
    end
    if (!done) begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_arvalid <= 1'b1;
    s_araddr  <= a;
    s_rready  <= 1'b1;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && s_rready) begin
        done = 1'b1;
        s_rready <= 1'b0;
        chk(s_rdata, ed);
        chk({30'h0, s_rresp}, {30'h0, er});
      end
    end
    if (!done) begin
      fails++;
      end_of_test();
    end
  endtask

  // let outputs settle a stated number of edges past the last change
  task automatic settle(input int c);
    repeat (c) @(posedge aclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hF;
    periph_out = '0;
    {ded_out_en, ded_out, ext_en, ext_val} = 16'h0000;
    fails = 0;
    comparisons = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    chk({28'h0, pad_ie}, 32'h0000_0000);
    chk({28'h0, pad_oe | rp_pin_in}, 32'h0000_0000);
    rdchk(RPM_OFF_SEL2, 32'h0000_0000, RPM_RESP_OKAY);
    rdchk(RPM_OFF_SEL3, 32'h0000_0000, RPM_RESP_OKAY);
    rdchk(RPM_OFF_ANSEL, 32'h0000_000F, RPM_RESP_OKAY);
    rdchk(RPM_OFF_DIR, 32'h0000_000F, RPM_RESP_OKAY);
    rdchk(RPM_OFF_LAT, 32'h0000_0000, RPM_RESP_OKAY);
    // field placement, unused bits read zero, unmapped and read-only places
    wr(RPM_OFF_SEL2, 32'hFFFF_FFFF, RPM_RESP_OKAY);
    rdchk(RPM_OFF_SEL2, 32'h0000_3F3F, RPM_RESP_OKAY);
    s_wstrb <= 4'h1;
    wr(RPM_OFF_SEL2, 32'h0000_0000, RPM_RESP_OKAY);
    s_wstrb <= 4'hF;
    rdchk(RPM_OFF_SEL2, 32'h0000_3F00, RPM_RESP_OKAY);
    wr(RPM_OFF_SEL3, 32'hFFFF_EA95, RPM_RESP_OKAY);
    rdchk(RPM_OFF_SEL3, 32'h0000_2A15, RPM_RESP_OKAY);
    wr(8'h18, 32'h0000_0001, RPM_RESP_SLV);
    rdchk(8'h18, 32'h0000_0000, RPM_RESP_SLV);
    wr(RPM_OFF_PINS, 32'h0000_000F, RPM_RESP_SLV);
    // function 1 on pins 38, 39 and 40, function 63 on pin 41, direction left as input
    wr(RPM_OFF_SEL2, 32'h0000_0101, RPM_RESP_OKAY);
    wr(RPM_OFF_SEL3, 32'h0000_3F01, RPM_RESP_OKAY);
    wr(RPM_OFF_LAT, 32'h0000_000F, RPM_RESP_OKAY);
    @(posedge aclk);
    periph_out <= 63'h1;
    settle(2);
    chk({28'h0, pad_oe}, 32'h0000_000F);
    chk({28'h0, pad_o}, 32'h0000_0007);
    @(posedge aclk);
    periph_out <= {1'b1, 62'h0};
    settle(2);
    chk({28'h0, pad_o}, 32'h0000_0008);
    // dedicated outputs on pins 38 and 39 win over the remapped function
    @(posedge aclk);
    ded_out_en <= 4'h3;
    ded_out <= 4'h2;
    settle(2);
    chk({28'h0, pad_oe}, 32'h0000_000F);
    chk({28'h0, pad_o}, 32'h0000_000A);
    wr(RPM_OFF_SEL3, 32'h0000_0000, RPM_RESP_OKAY);
    settle(2);
    chk({28'h0, pad_oe}, 32'h0000_0003);
    // direction gates only the general-purpose buffer
    wr(RPM_OFF_DIR, 32'h0000_0000, RPM_RESP_OKAY);
    wr(RPM_OFF_LAT, 32'h0000_0004, RPM_RESP_OKAY);
    settle(2);
    chk({28'h0, pad_oe}, 32'h0000_000F);
    chk({28'h0, pad_o}, 32'h0000_0006);
    wr(RPM_OFF_DIR, 32'h0000_000F, RPM_RESP_OKAY);
    settle(2);
    chk({28'h0, pad_oe}, 32'h0000_0003);
    // board drives pins 40 and 41, set as inputs; analog still selected
    @(posedge aclk);
    ext_en <= 4'hC;
    ext_val <= 4'h4;
    settle(5);
    chk({28'h0, rp_pin_in}, 32'h0000_0000);
    wr(RPM_OFF_ANSEL, 32'h0000_0000, RPM_RESP_OKAY);
    settle(5);
    chk({28'h0, pad_ie}, 32'h0000_000F);
    chk({28'h0, rp_pin_in}, 32'h0000_0006);
    @(posedge aclk);
    ext_val <= 4'h8;
    ded_out <= 4'h1;
    settle(5);
    chk({28'h0, rp_pin_in}, 32'h0000_0009);
    rdchk(RPM_OFF_PINS, 32'h0000_0009, RPM_RESP_OKAY);
    // pins 40 and 41 as outputs: direction does not gate their inputs
    wr(RPM_OFF_DIR, 32'h0000_0000, RPM_RESP_OKAY);
    settle(5);
    chk({28'h0, rp_pin_in}, 32'h0000_0005);
    wr(RPM_OFF_DIR, 32'h0000_000F, RPM_RESP_OKAY);
    // analog on pin 38: its input path closes while its output keeps driving
    wr(RPM_OFF_ANSEL, 32'h0000_0001, RPM_RESP_OKAY);
    settle(5);
    chk({28'h0, rp_pin_in}, 32'h0000_0008);
    chk({28'h0, pad_oe}, 32'h0000_0003);
    // second reset in mid-run
    @(posedge aclk);
    ded_out_en <= 4'h0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    chk({28'h0, pad_ie}, 32'h0000_0000);
    rdchk(RPM_OFF_ANSEL, 32'h0000_000F, RPM_RESP_OKAY);
    rdchk(RPM_OFF_SEL2, 32'h0000_0000, RPM_RESP_OKAY);
    end_of_test();
  end
endmodule // testbench
